// *** hdl/sync_sram_transparent_out.sv ***
// Synchronous 16K x 4 static RAM with registered inputs and a transparent output latch.
//
// Summary of operation
// - Register address, data, write and enable inputs.
// - Array holds 16,384 words of four bits.
// - Enable and write low store the data.
// - Write is self-timed from the rising edge.
// - Outputs float after clock falls during write.
// - Enable low, write high reads the word.
// - Enable high deselects; outputs float, write ignored.
// - Outputs change only while memory clock low.
// - Rising edge latches previous output until fall.
// - Read data valid per two clock-high regimes.
// - Outputs float from power-up until a read.
//
// The memory clock arrives as mem_clk_i and is sampled on sys_clk_i; both its
// edges are found after a three-stage synchroniser, so the memory cycle is many
// system cycles long. Inputs are captured on the detected rising edge.
`timescale 1ns/1ns
`include "sync_sram_regs.svh"
module sync_sram_transparent_out
  import sync_sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W,
  parameter int DEPTH  = `SRAM_DEPTH
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              mem_clk_i,
  input  wire logic [ADDR_W-1:0] addr_in_i,
  input  wire logic [DATA_W-1:0] wdata_in_i,
  input  wire logic              write_n_i,
  input  wire logic              chip_en_n_i,
  output logic      [DATA_W-1:0] rdata_out_o,
  output logic      [DATA_W-1:0] rdata_out_oe_n_o
);
  localparam int KLQV_CYC  = `SRAM_KLQV_CYC;
  // Cycles from a detected fall until the refreshed outputs can be sampled.
  localparam int FALL_TO_Q = KLQV_CYC + 1;

  initial
  begin
    if (DEPTH != (1 << ADDR_W) || DATA_W < 1 || KLQV_CYC > 15)
    begin
      $error("sync_sram_transparent_out: unsupported geometry");
    end
  end

  // Clock pin synchroniser; the first stage feeds only the second.
  logic [2:0] kclk_sync_d;
  logic [2:0] kclk_sync_q;
  logic       kclk_lvl_d;
  logic       kclk_lvl_q;
  logic       k_rise;
  logic       k_fall;

  always_comb
  begin
    kclk_sync_d = {kclk_sync_q[1:0], mem_clk_i};
    kclk_lvl_d  = kclk_lvl_q;
    if (kclk_sync_q[2] == kclk_sync_q[1])
    begin
      kclk_lvl_d = kclk_sync_q[2];
    end
  end

  assign k_rise = !kclk_lvl_q && kclk_lvl_d;
  assign k_fall = kclk_lvl_q && !kclk_lvl_d;

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      kclk_sync_q <= 3'h0;
      kclk_lvl_q  <= 1'b0;
    end
    else
    begin
      kclk_sync_q <= kclk_sync_d;
      kclk_lvl_q  <= kclk_lvl_d;
    end
  end

  // Input registers; pins are held stable around the memory clock edge by the
  // controller, so they are sampled directly on the detected rise.
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_d;
  logic [DATA_W-1:0] wdata_q;
  sram_op_e          op_d;
  sram_op_e          op_q;
  logic              wr_pulse_d;
  logic              wr_pulse_q;

  always_comb
  begin
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    op_d       = op_q;
    wr_pulse_d = 1'b0;
    if (k_rise)
    begin
      addr_d  = addr_in_i;
      wdata_d = wdata_in_i;
      unique case ({chip_en_n_i, write_n_i})
        2'b00:
        begin
          op_d       = OP_WRITE;
          wr_pulse_d = 1'b1;
        end
        2'b01:   op_d = OP_READ;
        default: op_d = OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      addr_q     <= '0;
      wdata_q    <= '0;
      op_q       <= OP_IDLE;
      wr_pulse_q <= 1'b0;
    end
    else
    begin
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      op_q       <= op_d;
      wr_pulse_q <= wr_pulse_d;
    end
  end

  // One-cycle internal write strobe: no write pulse shape is needed outside.
  logic [DATA_W-1:0] array_rdata;

  sram_array
  #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .DEPTH  (DEPTH)
  )
  u_array
  (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (wr_pulse_q),
    .addr_i    (addr_q),
    .wdata_i   (wdata_q),
    .rdata_o   (array_rdata)
  );

  // Output latch. After the memory clock falls it waits the low-phase delay
  // and then opens; it closes again on the next rise, holding its value.
  logic [DATA_W-1:0] qdata_d;
  logic [DATA_W-1:0] qdata_q;
  logic              qdrive_d;
  logic              qdrive_q;
  logic [3:0]        low_cnt_d;
  logic [3:0]        low_cnt_q;
  logic              latch_open;

  assign latch_open = !kclk_lvl_q && (low_cnt_q >= 4'(KLQV_CYC));

  always_comb
  begin
    qdata_d   = qdata_q;
    qdrive_d  = qdrive_q;
    low_cnt_d = low_cnt_q;
    if (k_fall || k_rise)
    begin
      low_cnt_d = 4'h1;
    end
    else if (!kclk_lvl_q && low_cnt_q != 4'hF)
    begin
      low_cnt_d = low_cnt_q + 4'h1;
    end
    // Held while the clock is high or the latch has not yet opened.
    if (latch_open && !k_rise)
    begin
      if (op_q == OP_READ)
      begin
        qdata_d  = array_rdata;
        qdrive_d = 1'b1;
      end
      else
      begin
        qdrive_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      qdata_q   <= '0;
      qdrive_q  <= 1'b0;
      low_cnt_q <= 4'h0;
    end
    else
    begin
      qdata_q   <= qdata_d;
      qdrive_q  <= qdrive_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  assign rdata_out_o      = qdata_q;
  assign rdata_out_oe_n_o = {DATA_W{!qdrive_q}};

  // Checks.
  sequence rise_s;
    k_rise;
  endsequence

  property write_store_p;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      rise_s ##0 (!chip_en_n_i && !write_n_i) |=> ##1 (u_array.mem_q[$past(addr_in_i, 2)]
                                                       == $past(wdata_in_i, 2));
  endproperty
  write_store_a: assert property (write_store_p)
    else $error("write data not stored");

  capture_addr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    k_rise |=> addr_q == $past(addr_in_i))
    else $error("address not captured on rise");

  high_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    kclk_lvl_q && $past(kclk_lvl_q) |-> $stable(qdata_q) && $stable(qdrive_q))
    else $error("outputs changed while clock high");

  write_float_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    op_q == OP_WRITE && latch_open |=> rdata_out_oe_n_o == '1)
    else $error("outputs driven during write");

  deselect_float_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    op_q == OP_IDLE && latch_open && !k_rise |=> !qdrive_q)
    else $error("outputs driven while deselected");

  read_drive_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    op_q == OP_READ && latch_open && !k_rise |=> qdrive_q && qdata_q == $past(array_rdata))
    else $error("read data not driven");

  fall_delay_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    k_fall |=> $stable(qdata_q) && $stable(qdrive_q))
    else $error("outputs moved before low-phase delay");

  fall_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    k_fall && op_q == OP_READ |-> ##FALL_TO_Q (qdrive_q && qdata_q == $past(array_rdata)))
    else $error("read data late after clock fall");

  wr_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_pulse_q |-> op_q == OP_WRITE ##1 !wr_pulse_q)
    else $error("write strobe malformed");

  reset_float_a: assert property (@(posedge sys_clk_i)
    !resetn_i |=> !qdrive_q)
    else $error("outputs driven after reset");
endmodule

// *** hdl/sync_sram_regs.svh ***
// Constants for the synchronous static RAM with transparent output latch.
`ifndef SYNC_SRAM_REGS_SVH
`define SYNC_SRAM_REGS_SVH
`define SRAM_ADDR_W      14
`define SRAM_DATA_W      4
`define SRAM_DEPTH       16384
`define SRAM_CLK_PERIOD_NS 10
`define SRAM_KHQV_NS     25
`define SRAM_KLQV_NS     10
`define SRAM_KLQV_CYC    ((`SRAM_KLQV_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
`define SRAM_KHQV_CYC    (`SRAM_KHQV_NS / `SRAM_CLK_PERIOD_NS)
`endif

// *** hdl/sync_sram_pkg.sv ***
// Types shared by the synchronous static RAM design.
package sync_sram_pkg;
  typedef enum logic [1:0]
  {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } sram_op_e;
endpackage

// *** hdl/sram_array.sv ***
// Flip-flop storage array with one synchronous write port and one read port.
`timescale 1ns/1ns
module sram_array
#(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 4,
  parameter int DEPTH  = 16384
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  initial
  begin
    if (DEPTH > (1 << ADDR_W))
    begin
      $error("sram_array: depth exceeds address range");
    end
  end

  // No reset on the array: unwritten locations are undefined, as in a real RAM.
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[addr_i];
endmodule

// *** verif/bus_ctrl_model.sv ***
// Bus controller model that runs one memory clock cycle per transfer.
`timescale 1ns/1ns
module bus_ctrl_model
#(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 4
)
(
  input  wire logic              sys_clk_i,
  input  wire logic [DATA_W-1:0] rdata_in_i,
  input  wire logic [DATA_W-1:0] oe_n_in_i,
  output logic                   mem_clk_o,
  output logic      [ADDR_W-1:0] addr_in_o,
  output logic      [DATA_W-1:0] wdata_in_o,
  output logic                   write_n_o,
  output logic                   chip_en_n_o
);
  initial
  begin
    mem_clk_o   = 1'b0;
    addr_in_o   = '0;
    wdata_in_o  = '0;
    write_n_o   = 1'b1;
    chip_en_n_o = 1'b1;
  end
  // Inputs settle two cycles before the clock rises and hold well past the
  // capture, since the design finds the edge several cycles late.
  task automatic xfer(input logic wn, input logic cn, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
    output logic [DATA_W-1:0] oe, output logic [DATA_W-1:0] held, output logic moved);
    logic [DATA_W-1:0] oe_h;
    @(negedge sys_clk_i);
    addr_in_o   = a;
    wdata_in_o  = d;
    write_n_o   = wn;
    chip_en_n_o = cn;
    repeat (2) @(negedge sys_clk_i);
    mem_clk_o = 1'b1;
    held      = rdata_in_i;
    oe_h      = oe_n_in_i;
    moved     = 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk_i);
      moved = moved | (rdata_in_i !== held) | (oe_n_in_i !== oe_h);
    end
    mem_clk_o = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    q  = rdata_in_i;
    oe = oe_n_in_i;
    // Released address, data and write lines show the inverse and chip enable goes high, so a stale value never passes.
    @(negedge sys_clk_i);
    addr_in_o   = ~a;
    wdata_in_o  = ~d;
    write_n_o   = ~wn;
    chip_en_n_o = 1'b1;
  endtask
endmodule

// *** verif/test_sync_sram_transparent_out.sv ***
// Self-checking bench for the synchronous RAM with a transparent output latch.
`timescale 1ns/1ns
module test_sync_sram_transparent_out;
  logic        sys_clk;
  logic        resetn;
  logic        mem_clk;
  logic [13:0] addr;
  logic [3:0]  wdata;
  logic        write_n;
  logic        chip_en_n;
  logic [3:0]  rdata;
  logic [3:0]  oe_n;
  logic [3:0]  q;
  logic [3:0]  oe;
  logic [3:0]  held;
  logic        moved;
  int          err_total;
  int          tests_run;

  sync_sram_transparent_out i_sync_sram_transparent_out
  (
    .sys_clk_i        (sys_clk),
    .resetn_i         (resetn),
    .mem_clk_i        (mem_clk),
    .addr_in_i        (addr),
    .wdata_in_i       (wdata),
    .write_n_i        (write_n),
    .chip_en_n_i      (chip_en_n),
    .rdata_out_o      (rdata),
    .rdata_out_oe_n_o (oe_n)
  );

  bus_ctrl_model i_bus_ctrl_model
  (
    .sys_clk_i   (sys_clk),
    .rdata_in_i  (rdata),
    .oe_n_in_i   (oe_n),
    .mem_clk_o   (mem_clk),
    .addr_in_o   (addr),
    .wdata_in_o  (wdata),
    .write_n_o   (write_n),
    .chip_en_n_o (chip_en_n)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic rd(input logic [13:0] a, input logic [3:0] exp);
    i_bus_ctrl_model.xfer(1'b1, 1'b0, a, 4'h0, q, oe, held, moved);
    chk(exp, q);
    chk(4'h0, oe);
    chk(4'h0, {3'h0, moved});
  endtask

  task automatic wr(input logic [13:0] a, input logic [3:0] d);
    i_bus_ctrl_model.xfer(1'b0, 1'b0, a, d, q, oe, held, moved);
    chk(4'hF, oe);
  endtask

  task automatic test_power_up();
    chk(4'hF, oe_n);
  endtask

  task automatic test_write_read();
    wr(14'h0000, 4'h5);
    rd(14'h0000, 4'h5);
    wr(14'h3FFF, 4'hA);
    rd(14'h3FFF, 4'hA);
  endtask

  task automatic test_deselect();
    i_bus_ctrl_model.xfer(1'b0, 1'b1, 14'h0000, 4'hF, q, oe, held, moved);
    chk(4'hF, oe);
    rd(14'h0000, 4'h5);
  endtask

  task automatic test_overwrite();
    wr(14'h0001, 4'hC);
    wr(14'h0001, 4'h3);
    rd(14'h0001, 4'h3);
  endtask

  task automatic test_hold();
    rd(14'h0000, 4'h5);
    rd(14'h3FFF, 4'hA);
    chk(4'h5, held);
  endtask

  initial
  begin
    err_total = 0;
    tests_run = 0;
    resetn    = 1'b0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    test_power_up();
    test_write_read();
    test_deselect();
    test_overwrite();
    test_hold();
    end_of_test();
  end

  // Eleven transfers of some twenty-one cycles each fit well inside this.
  initial
  begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule
